/* File: dsu_ctl_pkg.sv */
// Behaviour
// - Network mode runs 56k or 64k clear channel; local area mode is point-to-point.
// - Line rate starts in autodetect, then takes the detected 56k or 64k rate.
// - The 64k clear channel payload rides a 72 kbps line circuit.
// - Terminal clocks equal line rate minus the enabled management channel rate.
// - Internal timing, the default, uses the local clock as timing master in local area mode; network mode always uses the line clock.
// - External timing uses the terminal clock on the external clock input.
// - Receive timing recovers the line clock, but uses internal clock during tests.
// - Local area line rate is 56 or 64 kbps, default 64.
// - With timeout enabled, user tests end after the configured duration.
// - With timeout disabled, a test runs until manually stopped.
// - Terminal or network initiated tests are exempt from timeout.
// - Test duration is 1 to 120 minutes, default 10.
// - Network loopback commands latch loopback when enabled in network mode, ignored when disabled or in local area mode.
// - Optional scrambling, default off, must match at both ends; scramble_on stays off in local area mode.
// - V.54 loop-up starts loopback toward network; loop-down ends it.
// - With V.54 response disabled, the default, loop 2 sequences are ignored.
// - Management channel takes 1600, 4000 or 8000 bps; both ends match.
// - All-zero subnet mask becomes the class A, B or C default mask.
// - Address valid only if first byte 0..223 and not 127.
`default_nettype none
package dsu_ctl_pkg;

  // ---------------------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG  = 4'h0;
  localparam logic [3:0] ADDR_TEST    = 4'h1;
  localparam logic [3:0] ADDR_IP      = 4'h2;
  localparam logic [3:0] ADDR_MASK    = 4'h3;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_RATES   = 4'h5;
  localparam logic [3:0] ADDR_EFFMASK = 4'h6;

  // Command bits in the test register write.
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;

  // ---------------------------------------------------------------------------
  // Enumerations.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RATE_AUTO = 2'b00,
    RATE_56   = 2'b01,
    RATE_64   = 2'b10
  } net_rate_t;

  typedef enum logic [1:0] {
    TIM_INTERNAL = 2'b00,
    TIM_EXTERNAL = 2'b01,
    TIM_RECEIVE  = 2'b10
  } timing_t;

  typedef enum logic [1:0] {
    MGMT_OFF  = 2'b00,
    MGMT_1600 = 2'b01,
    MGMT_4000 = 2'b10,
    MGMT_8000 = 2'b11
  } mgmt_rate_t;

  typedef enum logic [1:0] {
    LB_IDLE = 2'b00,
    LB_USER = 2'b01,
    LB_NET  = 2'b10,
    LB_V54  = 2'b11
  } lb_state_t;

  // Configuration word as written by software.
  typedef struct packed {
    logic       local_area_point_to_point_mode;
    net_rate_t  net_rate;
    logic       local_area_point_to_point_mode_rate_64;
    timing_t    timing;
    logic       timeout_en;
    logic       net_lb_en;
    logic       scramble_en;
    logic       v54_en;
    mgmt_rate_t inband_mgmt_channel;
  } config_t;

  // Line-side loopback requests, one-cycle pulses.
  typedef struct packed {
    logic net_up;
    logic net_down;
    logic v54_up;
    logic v54_down;
  } line_cmd_t;

  localparam config_t CONFIG_RESET = '{
    local_area_point_to_point_mode: 1'b0,
    net_rate:                       RATE_AUTO,
    local_area_point_to_point_mode_rate_64:                   1'b1,
    timing:                         TIM_INTERNAL,
    timeout_en:                     1'b1,
    net_lb_en:                      1'b1,
    scramble_en:                    1'b0,
    v54_en:                         1'b0,
    inband_mgmt_channel:            MGMT_OFF
  };

  // ---------------------------------------------------------------------------
  // Rates in bps and timing constants.
  // ---------------------------------------------------------------------------
  localparam logic [16:0] BPS_56K     = 17'd56000;
  localparam logic [16:0] BPS_64K     = 17'd64000;
  localparam logic [16:0] BPS_72K     = 17'd72000;
  localparam logic [16:0] BPS_M1600   = 17'd1600;
  localparam logic [16:0] BPS_M4000   = 17'd4000;
  localparam logic [16:0] BPS_M8000   = 17'd8000;
  localparam logic [6:0]  DUR_MIN     = 7'd1;
  localparam logic [6:0]  DUR_MAX     = 7'd120;
  localparam logic [6:0]  DUR_RESET   = 7'd10;
  localparam int          CLK_HZ      = 100_000_000;
  localparam int          MINUTE_S    = 60;
  localparam longint      MINUTE_CYC  = longint'(CLK_HZ) * MINUTE_S;
  localparam logic [7:0]  CLASS_A_TOP = 8'd127;
  localparam logic [7:0]  CLASS_B_TOP = 8'd191;
  localparam logic [7:0]  CLASS_C_TOP = 8'd223;
  localparam logic [7:0]  LOOPNET     = 8'd127;

endpackage
`default_nettype wire

/* File: dsu_rate_timing_test_control.sv */
`timescale 1ns/1ps
`default_nettype none
module dsu_rate_timing_test_control #(
  parameter longint MINUTE_CYCLES = dsu_ctl_pkg::MINUTE_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic [3:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   line_sig_detect,
  input  wire logic                   line_detect_64,
  input  wire logic                   line_rx_clk,
  input  wire logic                   external_transmit_clock_in,
  input  wire dsu_ctl_pkg::line_cmd_t line_cmd,
  input  wire logic                   dte_test_req,
  input  wire logic                   frame_tick,
  output logic                        timing_tick,
  output logic                        loopback_on,
  output logic                        test_active,
  output logic                        scramble_on,
  output logic      [16:0]            line_circuit_bps,
  output logic      [16:0]            dte_clock_bps
);

  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  // Checks a management address: first byte 0..223, never 127.
  function automatic logic ip_ok(input logic [31:0] ip);
    ip_ok = (ip[31:24] <= dsu_ctl_pkg::CLASS_C_TOP) && (ip[31:24] != dsu_ctl_pkg::LOOPNET);
  endfunction

  // Maps a management channel setting to its rate.
  function automatic logic [16:0] mgmt_bps(input dsu_ctl_pkg::mgmt_rate_t m);
    case (m)
      dsu_ctl_pkg::MGMT_1600: mgmt_bps = dsu_ctl_pkg::BPS_M1600;
      dsu_ctl_pkg::MGMT_4000: mgmt_bps = dsu_ctl_pkg::BPS_M4000;
      dsu_ctl_pkg::MGMT_8000: mgmt_bps = dsu_ctl_pkg::BPS_M8000;
      default:                mgmt_bps = 17'd0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------------------
  logic [1:0] det_s_r;
  logic [1:0] d64_s_r;
  logic [1:0] rxc_s_r;
  logic [1:0] ext_s_r;
  logic       rxc_d_r;
  logic       ext_d_r;

  // Two flip-flops on every pin from outside the clock domain.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      det_s_r <= 2'b00;
      d64_s_r <= 2'b00;
      rxc_s_r <= 2'b00;
      ext_s_r <= 2'b00;
      rxc_d_r <= 1'b0;
      ext_d_r <= 1'b0;
    end else begin
      det_s_r <= {det_s_r[0], line_sig_detect};
      d64_s_r <= {d64_s_r[0], line_detect_64};
      rxc_s_r <= {rxc_s_r[0], line_rx_clk};
      ext_s_r <= {ext_s_r[0], external_transmit_clock_in};
      rxc_d_r <= rxc_s_r[1];
      ext_d_r <= ext_s_r[1];
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers.
  // ---------------------------------------------------------------------------
  dsu_ctl_pkg::config_t cfg_r;
  logic [6:0]           dur_r;
  logic [31:0]          ip_r;
  logic [31:0]          mask_r;
  logic                 ip_rej_r;
  logic                 user_start;
  logic                 user_stop;

  assign user_start = reg_wr && (reg_addr == dsu_ctl_pkg::ADDR_TEST) && reg_wdata[dsu_ctl_pkg::CMD_START];
  assign user_stop  = reg_wr && (reg_addr == dsu_ctl_pkg::ADDR_TEST) && reg_wdata[dsu_ctl_pkg::CMD_STOP];

  // Software writes; autodetect rate is replaced by hardware on detection.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= dsu_ctl_pkg::CONFIG_RESET;
    end else if (reg_wr && reg_addr == dsu_ctl_pkg::ADDR_CONFIG) begin
      cfg_r <= dsu_ctl_pkg::config_t'(reg_wdata[11:0]);
    end else if (!cfg_r.local_area_point_to_point_mode && cfg_r.net_rate == dsu_ctl_pkg::RATE_AUTO
                 && det_s_r[1]) begin
      cfg_r.net_rate <= d64_s_r[1] ? dsu_ctl_pkg::RATE_64 : dsu_ctl_pkg::RATE_56;
    end
  end

  // Duration clamps into 1..120 minutes.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dur_r <= dsu_ctl_pkg::DUR_RESET;
    end else if (reg_wr && reg_addr == dsu_ctl_pkg::ADDR_TEST) begin
      if (reg_wdata[14:8] < dsu_ctl_pkg::DUR_MIN) begin
        dur_r <= dsu_ctl_pkg::DUR_MIN;
      end else if (reg_wdata[14:8] > dsu_ctl_pkg::DUR_MAX) begin
        dur_r <= dsu_ctl_pkg::DUR_MAX;
      end else begin
        dur_r <= reg_wdata[14:8];
      end
    end
  end

  // Address accepted only when valid; otherwise kept and flagged.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ip_r     <= 32'h0000_0000;
      mask_r   <= 32'h0000_0000;
      ip_rej_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == dsu_ctl_pkg::ADDR_IP) begin
        ip_rej_r <= !ip_ok(reg_wdata);
        if (ip_ok(reg_wdata)) begin
          ip_r <= reg_wdata;
        end
      end
      if (reg_wr && reg_addr == dsu_ctl_pkg::ADDR_MASK) begin
        mask_r <= reg_wdata;
      end
    end
  end

  // Effective mask substitutes a class default for an all-zero mask.
  logic [31:0] eff_mask;
  always_comb begin
    eff_mask = mask_r;
    if (mask_r == 32'h0000_0000) begin
      if (ip_r[31:24] <= dsu_ctl_pkg::CLASS_A_TOP) begin
        eff_mask = 32'hff00_0000;
      end else if (ip_r[31:24] <= dsu_ctl_pkg::CLASS_B_TOP) begin
        eff_mask = 32'hffff_0000;
      end else begin
        eff_mask = 32'hffff_ff00;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Rates and timing source.
  // ---------------------------------------------------------------------------
  logic [16:0] op_bps;
  always_comb begin
    if (cfg_r.local_area_point_to_point_mode) begin
      op_bps = cfg_r.local_area_point_to_point_mode_rate_64 ? dsu_ctl_pkg::BPS_64K : dsu_ctl_pkg::BPS_56K;
    end else if (cfg_r.net_rate == dsu_ctl_pkg::RATE_64) begin
      op_bps = dsu_ctl_pkg::BPS_64K;
    end else if (cfg_r.net_rate == dsu_ctl_pkg::RATE_56) begin
      op_bps = dsu_ctl_pkg::BPS_56K;
    end else begin
      op_bps = 17'd0;
    end
  end

  // Registered rate outputs.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_circuit_bps <= 17'd0;
      dte_clock_bps    <= 17'd0;
      scramble_on      <= 1'b0;
    end else begin
      line_circuit_bps <= (!cfg_r.local_area_point_to_point_mode && cfg_r.net_rate == dsu_ctl_pkg::RATE_64)
                          ? dsu_ctl_pkg::BPS_72K : op_bps;
      dte_clock_bps    <= (op_bps == 17'd0) ? 17'd0
                          : op_bps - mgmt_bps(cfg_r.inband_mgmt_channel);
      scramble_on      <= cfg_r.scramble_en && !cfg_r.local_area_point_to_point_mode;
    end
  end

  // Timing edge selected from the chosen source.
  dsu_ctl_pkg::lb_state_t lb_r;
  logic rx_edge;
  logic ext_edge;
  assign rx_edge  = rxc_s_r[1] && !rxc_d_r;
  assign ext_edge = ext_s_r[1] && !ext_d_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timing_tick <= 1'b0;
    end else if (!cfg_r.local_area_point_to_point_mode) begin
      timing_tick <= rx_edge;
    end else begin
      case (cfg_r.timing)
        dsu_ctl_pkg::TIM_EXTERNAL: timing_tick <= ext_edge;
        dsu_ctl_pkg::TIM_RECEIVE:  timing_tick <= (lb_r != dsu_ctl_pkg::LB_IDLE) ? frame_tick
                                                  : rx_edge;
        default:                   timing_tick <= frame_tick;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Loopback and test control.
  // ---------------------------------------------------------------------------
  // Wide enough to hold a full minute of core clocks at the real clock rate.
  logic [32:0] cyc_r;
  logic [6:0]  min_r;
  logic        timed_out;
  logic        end_req;
  logic        net_mode;
  assign net_mode  = !cfg_r.local_area_point_to_point_mode;
  assign timed_out = (lb_r == dsu_ctl_pkg::LB_USER) && cfg_r.timeout_en
                     && (min_r >= dur_r);

  // Minute counter runs only for user tests.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_r <= 33'd0;
      min_r <= 7'd0;
    end else if (lb_r != dsu_ctl_pkg::LB_USER) begin
      cyc_r <= 33'd0;
      min_r <= 7'd0;
    end else if (cyc_r == 33'(MINUTE_CYCLES - 1)) begin
      cyc_r <= 33'd0;
      min_r <= min_r + 7'd1;
    end else begin
      cyc_r <= cyc_r + 33'd1;
    end
  end

  // Loopback state; terminal and network tests never time out.
  always_comb begin
    case (lb_r)
      dsu_ctl_pkg::LB_USER: end_req = user_stop || timed_out;
      dsu_ctl_pkg::LB_NET:  end_req = line_cmd.net_down || user_stop;
      dsu_ctl_pkg::LB_V54:  end_req = line_cmd.v54_down || user_stop;
      default:              end_req = 1'b0;
    endcase
  end

  // An end request wins over any start request in the same cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lb_r <= dsu_ctl_pkg::LB_IDLE;
    end else if (end_req) begin
      lb_r <= dsu_ctl_pkg::LB_IDLE;
    end else if (lb_r == dsu_ctl_pkg::LB_IDLE) begin
      if (net_mode && cfg_r.net_lb_en && line_cmd.net_up) begin
        lb_r <= dsu_ctl_pkg::LB_NET;
      end else if (cfg_r.v54_en && line_cmd.v54_up) begin
        lb_r <= dsu_ctl_pkg::LB_V54;
      end else if (dte_test_req) begin
        lb_r <= dsu_ctl_pkg::LB_NET;
      end else if (user_start) begin
        lb_r <= dsu_ctl_pkg::LB_USER;
      end
    end
  end

  assign loopback_on = (lb_r != dsu_ctl_pkg::LB_IDLE);
  assign test_active = (lb_r != dsu_ctl_pkg::LB_IDLE);

  // ---------------------------------------------------------------------------
  // Register read port.
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        dsu_ctl_pkg::ADDR_CONFIG:  reg_rdata <= {20'h0, cfg_r};
        dsu_ctl_pkg::ADDR_TEST:    reg_rdata <= {17'h0, dur_r, 8'h00};
        dsu_ctl_pkg::ADDR_IP:      reg_rdata <= ip_r;
        dsu_ctl_pkg::ADDR_MASK:    reg_rdata <= mask_r;
        dsu_ctl_pkg::ADDR_STATUS:  reg_rdata <= {16'h0, 1'b0, min_r, 5'h0, ip_rej_r, lb_r};
        dsu_ctl_pkg::ADDR_RATES:   reg_rdata <= {15'h0, dte_clock_bps};
        dsu_ctl_pkg::ADDR_EFFMASK: reg_rdata <= eff_mask;
        default:                   reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  property p_v54_ignored;
    @(posedge core_clk) disable iff (!reset_n)
    (lb_r == dsu_ctl_pkg::LB_IDLE && !cfg_r.v54_en && line_cmd.v54_up && !dte_test_req
     && !user_start && !(net_mode && cfg_r.net_lb_en && line_cmd.net_up))
    |=> lb_r == dsu_ctl_pkg::LB_IDLE;
  endproperty
  a_v54_ignored: assert property (p_v54_ignored) else $error("V54 up taken while disabled.");

  property p_net_ignored;
    @(posedge core_clk) disable iff (!reset_n)
    (lb_r == dsu_ctl_pkg::LB_IDLE && !cfg_r.net_lb_en && !(cfg_r.v54_en && line_cmd.v54_up)
     && line_cmd.net_up && !dte_test_req && !user_start) |=> lb_r == dsu_ctl_pkg::LB_IDLE;
  endproperty
  a_net_ignored: assert property (p_net_ignored) else $error("Network loop taken while disabled.");

  property p_end_fast;
    @(posedge core_clk) disable iff (!reset_n)
    end_req |=> !loopback_on;
  endproperty
  a_end_fast: assert property (p_end_fast) else $error("Loopback not removed.");

  property p_no_timeout_exempt;
    @(posedge core_clk) disable iff (!reset_n)
    (lb_r == dsu_ctl_pkg::LB_NET && !line_cmd.net_down && !user_stop) |=> lb_r == dsu_ctl_pkg::LB_NET;
  endproperty
  a_no_timeout_exempt: assert property (p_no_timeout_exempt) else $error("Exempt test ended.");

  property p_dte_rate;
    @(posedge core_clk) disable iff (!reset_n)
    (op_bps != 17'd0) ##1 (op_bps == $past(op_bps)) && $stable(cfg_r.inband_mgmt_channel)
    |-> dte_clock_bps == op_bps - mgmt_bps(cfg_r.inband_mgmt_channel);
  endproperty
  a_dte_rate: assert property (p_dte_rate) else $error("Terminal clock rate wrong.");

  property p_ip_guard;
    @(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == dsu_ctl_pkg::ADDR_IP && !ip_ok(reg_wdata)) |=> $stable(ip_r) && ip_rej_r;
  endproperty
  a_ip_guard: assert property (p_ip_guard) else $error("Bad address accepted.");

  property p_dur_range;
    @(posedge core_clk) disable iff (!reset_n)
    dur_r >= dsu_ctl_pkg::DUR_MIN && dur_r <= dsu_ctl_pkg::DUR_MAX;
  endproperty
  a_dur_range: assert property (p_dur_range) else $error("Duration out of range.");

  property p_autodetect;
    @(posedge core_clk) disable iff (!reset_n)
    (net_mode && cfg_r.net_rate == dsu_ctl_pkg::RATE_AUTO && det_s_r[1] && !reg_wr)
    |=> cfg_r.net_rate != dsu_ctl_pkg::RATE_AUTO;
  endproperty
  a_autodetect: assert property (p_autodetect) else $error("Rate not detected.");

endmodule
`default_nettype wire

/* File: dsu_far_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far end of the link: line receive clock and terminal transmit clock.
module dsu_far_end_model #(
  parameter realtime RX_HALF  = 80.0,
  parameter realtime EXT_HALF = 80.0
) (
  input  wire logic rx_run,
  input  wire logic ext_run,
  output logic      line_rx_clk,
  output logic      external_transmit_clock_in
);
  // Recovered line clock runs only while the far end sends and rests low otherwise.
  initial line_rx_clk = 1'b0;
  always begin
    #(RX_HALF);
    line_rx_clk = rx_run ? ~line_rx_clk : 1'b0;
  end

  // Terminal clock at the same rate as the line receive clock, held low when idle.
  initial external_transmit_clock_in = 1'b0;
  always begin
    #(EXT_HALF);
    external_transmit_clock_in = ext_run ? ~external_transmit_clock_in : 1'b0;
  end
endmodule
`default_nettype wire

/* File: dsu_rate_timing_test_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dsu_rate_timing_test_control_test;
  // ---------------------------------------------------------------------------
  // Signals and instances.
  // ---------------------------------------------------------------------------
  logic core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
  logic line_sig_detect = 1'b0, line_detect_64 = 1'b0, dte_test_req = 1'b0;
  logic frame_tick = 1'b0, rx_run = 1'b0, ext_run = 1'b0;
  logic line_rx_clk, external_transmit_clock_in, timing_tick, loopback_on;
  logic test_active, scramble_on;
  logic [16:0] line_circuit_bps, dte_clock_bps;
  logic [2:0] fcnt = 3'h0;
  dsu_ctl_pkg::line_cmd_t line_cmd = '0;
  dsu_ctl_pkg::config_t c;
  int errors = 0, compares = 0, k;
  logic [16:0] m[4] = '{17'd0, 17'd1600, 17'd4000, 17'd8000};

  dsu_rate_timing_test_control #(.MINUTE_CYCLES(100)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .line_sig_detect(line_sig_detect), .line_detect_64(line_detect_64),
    .line_rx_clk(line_rx_clk), .external_transmit_clock_in(external_transmit_clock_in),
    .line_cmd(line_cmd), .dte_test_req(dte_test_req), .frame_tick(frame_tick),
    .timing_tick(timing_tick), .loopback_on(loopback_on), .test_active(test_active),
    .scramble_on(scramble_on), .line_circuit_bps(line_circuit_bps),
    .dte_clock_bps(dte_clock_bps));

  dsu_far_end_model far_u (.rx_run(rx_run), .ext_run(ext_run), .line_rx_clk(line_rx_clk),
    .external_transmit_clock_in(external_transmit_clock_in));

  // Core clock at 100 MHz.
  always #5 core_clk = ~core_clk;

  // Local frame tick once every eight cycles.
  always @(posedge core_clk) begin
    fcnt <= fcnt + 3'h1;
    frame_tick <= (fcnt == 3'h7);
  end

  // ---------------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cmd(input dsu_ctl_pkg::line_cmd_t v);
    @(posedge core_clk);
    line_cmd <= v;
    @(posedge core_clk);
    line_cmd <= '0;
  endtask

  // Waits a bounded number of cycles for the test flag to take a level.
  task automatic wait_active(input logic v, input int n);
    for (int i = 0; i < n && test_active !== v; i++) @(posedge core_clk) #1;
    if (test_active !== v) begin
      errors++;
      conclude();
    end
  endtask

  task automatic ticks(input int lo, input int hi);
    k = 0;
    repeat (400) begin
      @(posedge core_clk) #1;
      if (timing_tick === 1'b1) k++;
    end
    chk(32'h1, 32'(k >= lo && k <= hi));
  endtask

  task automatic setcfg();
    wr(dsu_ctl_pkg::ADDR_CONFIG, 32'(c));
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rd(dsu_ctl_pkg::ADDR_CONFIG, rd_v);
    chk(32'(dsu_ctl_pkg::CONFIG_RESET), rd_v);
    chk(32'h0, {31'h0, scramble_on});
    rd(dsu_ctl_pkg::ADDR_TEST, rd_v);
    chk(32'h0a, 32'(rd_v[14:8]));
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0000);
    rd(dsu_ctl_pkg::ADDR_TEST, rd_v);
    chk(32'h01, 32'(rd_v[14:8]));
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_7f00);
    rd(dsu_ctl_pkg::ADDR_TEST, rd_v);
    chk(32'h78, 32'(rd_v[14:8]));
    rd(4'h7, rd_v);
    chk(32'h0, rd_v);
  endtask

  task automatic t_ip();
    wr(dsu_ctl_pkg::ADDR_IP, 32'h0a01_0203);
    wr(dsu_ctl_pkg::ADDR_MASK, 32'h0);
    rd(dsu_ctl_pkg::ADDR_EFFMASK, rd_v);
    chk(32'hff00_0000, rd_v);
    wr(dsu_ctl_pkg::ADDR_IP, 32'hac10_0001);
    rd(dsu_ctl_pkg::ADDR_EFFMASK, rd_v);
    chk(32'hffff_0000, rd_v);
    wr(dsu_ctl_pkg::ADDR_IP, 32'hdfff_ffff);
    rd(dsu_ctl_pkg::ADDR_EFFMASK, rd_v);
    chk(32'hffff_ff00, rd_v);
    wr(dsu_ctl_pkg::ADDR_MASK, 32'hffff_fff0);
    rd(dsu_ctl_pkg::ADDR_EFFMASK, rd_v);
    chk(32'hffff_fff0, rd_v);
    wr(dsu_ctl_pkg::ADDR_IP, 32'h7f00_0001);
    rd(dsu_ctl_pkg::ADDR_IP, rd_v);
    chk(32'hdfff_ffff, rd_v);
    rd(dsu_ctl_pkg::ADDR_STATUS, rd_v);
    chk(32'h1, 32'(rd_v[2]));
    wr(dsu_ctl_pkg::ADDR_IP, 32'he000_0001);
    rd(dsu_ctl_pkg::ADDR_IP, rd_v);
    chk(32'hdfff_ffff, rd_v);
  endtask

  task automatic t_rates();
    @(posedge core_clk);
    line_detect_64 <= 1'b1;
    line_sig_detect <= 1'b1;
    repeat (12) @(posedge core_clk);
    #1 chk(32'(dsu_ctl_pkg::BPS_64K), 32'(dte_clock_bps));
    for (int i = 0; i < 4; i++) begin
      c = dsu_ctl_pkg::CONFIG_RESET;
      c.inband_mgmt_channel = dsu_ctl_pkg::mgmt_rate_t'(i);
      c.net_rate = dsu_ctl_pkg::RATE_64;
      setcfg();
      repeat (3) @(posedge core_clk);
      #1 chk(32'(dsu_ctl_pkg::BPS_72K), 32'(line_circuit_bps));
      chk(32'(dsu_ctl_pkg::BPS_64K - m[i]), 32'(dte_clock_bps));
      c.net_rate = dsu_ctl_pkg::RATE_56;
      c.scramble_en = 1'b1;
      setcfg();
      repeat (3) @(posedge core_clk);
      #1 chk(32'(dsu_ctl_pkg::BPS_56K - m[i]), 32'(dte_clock_bps));
      chk(32'h1, {31'h0, scramble_on});
      c.local_area_point_to_point_mode = 1'b1;
      c.local_area_point_to_point_mode_rate_64 = i[0];
      setcfg();
      repeat (3) @(posedge core_clk);
      #1 chk(32'((i[0] ? dsu_ctl_pkg::BPS_64K : dsu_ctl_pkg::BPS_56K) - m[i]),
             32'(dte_clock_bps));
    end
    @(posedge core_clk);
    line_detect_64 <= 1'b0;
    wr(dsu_ctl_pkg::ADDR_CONFIG, 32'(dsu_ctl_pkg::CONFIG_RESET));
    repeat (6) @(posedge core_clk);
    rd(dsu_ctl_pkg::ADDR_RATES, rd_v);
    chk(32'(dsu_ctl_pkg::BPS_56K), rd_v);
  endtask

  task automatic t_timing();
    c = dsu_ctl_pkg::CONFIG_RESET;
    c.local_area_point_to_point_mode = 1'b1;
    c.timeout_en = 1'b0;
    setcfg();
    ticks(48, 52);
    ext_run <= 1'b1;
    c.timing = dsu_ctl_pkg::TIM_EXTERNAL;
    setcfg();
    ticks(23, 27);
    ext_run <= 1'b0;
    rx_run <= 1'b1;
    c.timing = dsu_ctl_pkg::TIM_RECEIVE;
    setcfg();
    ticks(23, 27);
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0a01);
    ticks(48, 52);
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0a02);
    rx_run <= 1'b0;
  endtask

  task automatic t_timeout();
    c = dsu_ctl_pkg::CONFIG_RESET;
    setcfg();
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0201);
    repeat (170) @(posedge core_clk);
    #1 chk(32'h1, {31'h0, test_active});
    rd(dsu_ctl_pkg::ADDR_STATUS, rd_v);
    chk(32'h1, 32'(rd_v[1:0]));
    wait_active(1'b0, 60);
    chk(32'h0, {31'h0, loopback_on});
    @(posedge core_clk);
    dte_test_req <= 1'b1;
    @(posedge core_clk);
    dte_test_req <= 1'b0;
    repeat (400) @(posedge core_clk);
    #1 chk(32'h1, {31'h0, test_active});
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0202);
    wait_active(1'b0, 2);
    c.timeout_en = 1'b0;
    setcfg();
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0101);
    repeat (400) @(posedge core_clk);
    #1 chk(32'h1, {31'h0, test_active});
    wr(dsu_ctl_pkg::ADDR_TEST, 32'h0000_0102);
    wait_active(1'b0, 2);
  endtask

  task automatic t_loops();
    c = dsu_ctl_pkg::CONFIG_RESET;
    setcfg();
    cmd('{net_up: 1'b1, default: 1'b0});
    wait_active(1'b1, 4);
    chk(32'h1, {31'h0, loopback_on});
    rd(dsu_ctl_pkg::ADDR_STATUS, rd_v);
    chk(32'h2, 32'(rd_v[1:0]));
    cmd('{net_down: 1'b1, default: 1'b0});
    wait_active(1'b0, 2);
    cmd('{v54_up: 1'b1, default: 1'b0});
    repeat (5) @(posedge core_clk);
    #1 chk(32'h0, {31'h0, loopback_on});
    c.net_lb_en = 1'b0;
    c.v54_en = 1'b1;
    setcfg();
    cmd('{net_up: 1'b1, default: 1'b0});
    repeat (5) @(posedge core_clk);
    #1 chk(32'h0, {31'h0, loopback_on});
    cmd('{v54_up: 1'b1, default: 1'b0});
    wait_active(1'b1, 4);
    rd(dsu_ctl_pkg::ADDR_STATUS, rd_v);
    chk(32'h3, 32'(rd_v[1:0]));
    cmd('{v54_down: 1'b1, default: 1'b0});
    wait_active(1'b0, 2);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------------------
  // Holds reset for four cycles, checks idle outputs, then runs every scenario.
  initial begin
    repeat (4) @(posedge core_clk);
    chk(32'h0, {30'h0, test_active, loopback_on});
    reset_n <= 1'b1;
    t_regs();
    t_ip();
    t_rates();
    t_timing();
    t_timeout();
    t_loops();
    conclude();
  end

  // Cuts a hung run short and reports it as a mismatch.
  initial begin
    #500000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
